// File: core/delay_timer_pkg.sv
// constants, register map and delay conversion function for the delay timer blocks
package delay_timer_pkg;
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned TICK_MS         = 10;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TW              = 26;
    // timebase limits: fixed setting in 10 ms ticks, then raw referenced value limits
    localparam logic [TW-1:0] SEC_MAX_TICKS = 26'd9999;
    localparam logic [TW-1:0] MIN_MAX_TICKS = 26'd599900;
    localparam logic [TW-1:0] HR_MAX_TICKS  = 26'd35994000;
    localparam logic [15:0] REF_MS_MAX      = 16'h270b;
    localparam logic [15:0] REF_SM_MAX      = 16'h176f;
    // register byte offsets
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_ON_T   = 8'h04;
    localparam logic [7:0] A_OFF_T  = 8'h08;
    localparam logic [7:0] A_HI_T   = 8'h0c;
    localparam logic [7:0] A_LO_T   = 8'h10;
    localparam logic [7:0] A_STAT   = 8'h14;
    localparam logic [7:0] A_ON_EL  = 8'h18;
    localparam logic [7:0] A_OFF_EL = 8'h1c;
    localparam logic [7:0] A_OO_EL  = 8'h20;
    // delay setting word: [15:0] value, [17:16] timebase, [18] from block
    localparam int unsigned F_BASE  = 16;
    localparam int unsigned F_REF   = 18;
    localparam logic [1:0] TB_SEC   = 2'h0;
    localparam logic [1:0] TB_MIN   = 2'h1;
    localparam logic [1:0] TB_HR    = 2'h2;
    localparam logic [18:0] DLY_RST = 19'h00064;

    // delay setting converted to 10 ms ticks, clamped to range
    function automatic logic [TW-1:0] to_ticks(input logic [18:0] d,
                                               input logic [15:0] refv);
        logic [15:0] v;
        logic [31:0] t;
        v = d[F_REF] ? refv : d[15:0];
        t = 32'h0;
        if (d[F_REF]) begin
            unique case (d[17:16])
                TB_SEC: t = {16'h0, (v > REF_MS_MAX) ? REF_MS_MAX : v} / 10;
                TB_MIN: t = {16'h0, (v > REF_SM_MAX) ? REF_SM_MAX : v} * 100;
                default: t = {16'h0, (v > REF_SM_MAX) ? REF_SM_MAX : v}
                             * 6000;
            endcase
            if (t > 32'(HR_MAX_TICKS)) begin
                t = 32'(HR_MAX_TICKS);
            end
        end else begin
            unique case (d[17:16])
                TB_SEC: t = 32'(v);
                TB_MIN: t = 32'(v) * 100;
                default: t = 32'(v) * 6000;
            endcase
            if (d[17:16] == TB_SEC && t > 32'(SEC_MAX_TICKS)) begin
                t = 32'(SEC_MAX_TICKS);
            end
            if (d[17:16] == TB_MIN && t > 32'(MIN_MAX_TICKS)) begin
                t = 32'(MIN_MAX_TICKS);
            end
            if (t > 32'(HR_MAX_TICKS)) begin
                t = 32'(HR_MAX_TICKS);
            end
        end
        if (t == 32'h0) begin
            t = 32'h1;
        end
        return t[TW-1:0];
    endfunction
endpackage

// File: core/tick_gen.sv
// common 10 ms evaluation tick
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
    parameter int unsigned CYCLES = delay_timer_pkg::TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      tick
);
    typedef struct packed {
        logic [17:0] cnt;
    } tick_st_t;
    tick_st_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (s_r.cnt == 18'(CYCLES - 1)) begin // R19
            s_nxt.cnt = 18'h0;
        end else begin
            s_nxt.cnt = s_r.cnt + 18'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = (s_r.cnt == 18'(CYCLES - 1));

    AST_TICK_SPACING: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> !tick) // R19
        else $error("tick lasted more than one cycle");
endmodule
`default_nettype wire

// File: core/ref_mux.sv
// selects a source block's actual value by block number
`timescale 1ns/1ps
`default_nettype none
module ref_mux #(
    parameter int unsigned NSRC = 4
) (
    input  wire logic [NSRC*16-1:0] src_values,
    input  wire logic [1:0]         sel,
    output logic [15:0]             value
);
    // sources: comparator, threshold trigger, amplifier, counter
    always_comb begin
        value = src_values[sel*16 +: 16]; // R09
    end
endmodule
`default_nettype wire

// File: core/delay_timers.sv
// on-delay, off-delay and on/off-delay timers with an AXI4-Lite slave
// Notes on behaviour
// R01 - on-delay counts elapsed time from zero on each rising trigger
// R02 - on-delay output rises when elapsed reaches delay with trigger held
// R03 - on-delay trigger drop before expiry clears elapsed, output stays low
// R04 - on-delay output is low whenever its trigger is low
// R05 - retention off clears outputs and elapsed after power loss; on keeps them
// R06 - fixed delay: seconds, minutes or hours timebase with own limits
// R07 - referenced value counts ms, s or min; limit 5999 for s and min
// R08 - out-of-range referenced value is clamped to nearest valid value
// R09 - delay source chosen by block number among four actual values
// R10 - off-delay output rises at once with trigger
// R11 - off-delay times from falling trigger, output clears at delay
// R12 - off-delay new trigger pulse restarts elapsed from zero
// R13 - off-delay clear input resets elapsed and output at any time
// R14 - on/off-delay rising trigger times high delay, then output sets
// R15 - on/off-delay trigger drop before high delay ends clears timing
// R16 - on/off-delay falling trigger starts low delay timing
// R17 - on/off-delay output clears when low delay ends with trigger low
// R18 - on/off-delay trigger return before low delay ends keeps output high
// R19 - all timers step on one common 10 ms tick, edges sampled per tick
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module delay_timers #(
    parameter int unsigned TICK_CYCLES = delay_timer_pkg::TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        power_lost,
    input  wire logic        on_trigger,
    input  wire logic        off_trigger,
    input  wire logic        off_clear,
    input  wire logic        onoff_trigger,
    input  wire logic [63:0] src_values,
    output logic             on_output,
    output logic             off_output,
    output logic             onoff_output,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam int TW = delay_timer_pkg::TW;

    typedef struct packed {
        // ctrl: [2:0] retention per block, [4:3] on src, [6:5] off src,
        // [8:7] hi src, [10:9] lo src
        logic [10:0]   ctrl;
        logic [18:0]   on_dly;
        logic [18:0]   off_dly;
        logic [18:0]   hi_dly;
        logic [18:0]   lo_dly;
        logic          on_trg;
        logic          off_trg;
        logic          oo_trg;
        logic [TW-1:0] on_el;
        logic [TW-1:0] off_el;
        logic [TW-1:0] oo_el;
        logic          off_run;
        logic          oo_run;
        logic          on_q;
        logic          off_q;
        logic          oo_q;
        logic          aw_got;
        logic          w_got;
        logic [7:0]    awa;
        logic [31:0]   wd;
        logic [3:0]    ws;
        logic          bv;
        logic [1:0]    br;
        logic          rv;
        logic [31:0]   rd;
        logic [1:0]    rr;
    } st_t;
    st_t s_r, s_nxt;

    // reset release goes through two flops before the rest uses it
    logic rst_n;
    logic rs1_r, rs2_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end
    assign rst_n = rs2_r;

    logic tick;
    tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick)
    );

    logic [15:0] rv_on, rv_off, rv_hi, rv_lo;
    ref_mux u_on  (.src_values(src_values), .sel(s_r.ctrl[4:3]),
                   .value(rv_on));
    ref_mux u_off (.src_values(src_values), .sel(s_r.ctrl[6:5]),
                   .value(rv_off));
    ref_mux u_hi  (.src_values(src_values), .sel(s_r.ctrl[8:7]),
                   .value(rv_hi));
    ref_mux u_lo  (.src_values(src_values), .sel(s_r.ctrl[10:9]),
                   .value(rv_lo));

    logic [TW-1:0] t_on, t_off, t_hi, t_lo;
    always_comb begin
        t_on  = delay_timer_pkg::to_ticks(s_r.on_dly, rv_on); // R06 R07 R08
        t_off = delay_timer_pkg::to_ticks(s_r.off_dly, rv_off);
        t_hi  = delay_timer_pkg::to_ticks(s_r.hi_dly, rv_hi);
        t_lo  = delay_timer_pkg::to_ticks(s_r.lo_dly, rv_lo);
    end

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0] wm;
    logic        do_w, do_r;

    always_comb begin
        s_nxt = s_r;
        wm = 32'h0;
        do_w = s_r.aw_got && s_r.w_got && !s_r.bv;
        do_r = s_axi_arvalid && !s_r.rv;
        // ---- timers, evaluated once per tick
        if (tick) begin // R19
            s_nxt.on_trg  = on_trigger;
            s_nxt.off_trg = off_trigger;
            s_nxt.oo_trg  = onoff_trigger;
            // on-delay
            if (!on_trigger) begin
                s_nxt.on_el = '0; // R03
                s_nxt.on_q  = 1'b0; // R04
            end else if (!s_r.on_trg) begin
                s_nxt.on_el = '0; // R01
            end else if (s_r.on_el < t_on) begin
                s_nxt.on_el = s_r.on_el + 1'b1;
                if (s_r.on_el + 1'b1 >= t_on) begin
                    s_nxt.on_q = 1'b1; // R02
                end
            end
            // off-delay
            if (off_trigger) begin
                s_nxt.off_q   = 1'b1; // R10
                s_nxt.off_el  = '0; // R12
                s_nxt.off_run = 1'b0;
            end else if (s_r.off_trg) begin
                s_nxt.off_run = 1'b1; // R11
                s_nxt.off_el  = '0;
            end else if (s_r.off_run) begin
                s_nxt.off_el = s_r.off_el + 1'b1;
                if (s_r.off_el + 1'b1 >= t_off) begin
                    s_nxt.off_q   = 1'b0; // R11
                    s_nxt.off_run = 1'b0;
                end
            end
            // on/off-delay: run flag marks a pending change
            if (onoff_trigger != s_r.oo_trg) begin
                s_nxt.oo_el  = '0; // R14 R16
                s_nxt.oo_run = (onoff_trigger != s_r.oo_q);
            end else if (onoff_trigger == s_r.oo_q) begin
                s_nxt.oo_el  = '0; // R15 R18
                s_nxt.oo_run = 1'b0;
            end else if (s_r.oo_run) begin
                s_nxt.oo_el = s_r.oo_el + 1'b1;
                if (s_r.oo_el + 1'b1 >=
                    (onoff_trigger ? t_hi : t_lo)) begin
                    s_nxt.oo_q   = onoff_trigger; // R14 R17
                    s_nxt.oo_run = 1'b0;
                    s_nxt.oo_el  = '0;
                end
            end else begin
                // level differs from output but no edge seen: time it
                s_nxt.oo_run = 1'b1;
            end
        end
        // clear input works at once, outside the tick
        if (off_clear) begin
            s_nxt.off_el  = '0; // R13
            s_nxt.off_q   = 1'b0; // R13
            s_nxt.off_run = 1'b0;
        end
        // power loss: blocks without retention lose their state
        if (power_lost) begin
            if (!s_r.ctrl[0]) begin
                s_nxt.on_el = '0; // R05
                s_nxt.on_q  = 1'b0;
                s_nxt.on_trg = 1'b0;
            end
            if (!s_r.ctrl[1]) begin
                s_nxt.off_el  = '0; // R05
                s_nxt.off_q   = 1'b0;
                s_nxt.off_run = 1'b0;
                s_nxt.off_trg = 1'b0;
            end
            if (!s_r.ctrl[2]) begin
                s_nxt.oo_el  = '0; // R05
                s_nxt.oo_q   = 1'b0;
                s_nxt.oo_run = 1'b0;
                s_nxt.oo_trg = 1'b0;
            end
        end
        // ---- AXI4-Lite write
        if (s_axi_awvalid && !s_r.aw_got) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awa    = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !s_r.w_got) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wd    = s_axi_wdata;
            s_nxt.ws    = s_axi_wstrb;
        end
        if (do_w) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bv     = 1'b1;
            s_nxt.br     = 2'h0;
            unique case (s_r.awa)
                delay_timer_pkg::A_CTRL: begin
                    wm = merge({21'h0, s_r.ctrl}, s_r.wd, s_r.ws);
                    s_nxt.ctrl = wm[10:0];
                end
                delay_timer_pkg::A_ON_T: begin
                    wm = merge({13'h0, s_r.on_dly}, s_r.wd, s_r.ws);
                    s_nxt.on_dly = wm[18:0];
                end
                delay_timer_pkg::A_OFF_T: begin
                    wm = merge({13'h0, s_r.off_dly}, s_r.wd, s_r.ws);
                    s_nxt.off_dly = wm[18:0];
                end
                delay_timer_pkg::A_HI_T: begin
                    wm = merge({13'h0, s_r.hi_dly}, s_r.wd, s_r.ws);
                    s_nxt.hi_dly = wm[18:0];
                end
                delay_timer_pkg::A_LO_T: begin
                    wm = merge({13'h0, s_r.lo_dly}, s_r.wd, s_r.ws);
                    s_nxt.lo_dly = wm[18:0];
                end
                default: s_nxt.br = 2'h2;
            endcase
        end
        if (s_r.bv && s_axi_bready) begin
            s_nxt.bv = 1'b0;
        end
        // ---- AXI4-Lite read
        if (do_r) begin
            s_nxt.rv = 1'b1;
            s_nxt.rr = 2'h0;
            unique case (s_axi_araddr[7:0])
                delay_timer_pkg::A_CTRL:   s_nxt.rd = {21'h0, s_r.ctrl};
                delay_timer_pkg::A_ON_T:   s_nxt.rd = {13'h0, s_r.on_dly};
                delay_timer_pkg::A_OFF_T:  s_nxt.rd = {13'h0, s_r.off_dly};
                delay_timer_pkg::A_HI_T:   s_nxt.rd = {13'h0, s_r.hi_dly};
                delay_timer_pkg::A_LO_T:   s_nxt.rd = {13'h0, s_r.lo_dly};
                delay_timer_pkg::A_STAT:
                    s_nxt.rd = {27'h0, s_r.oo_run, s_r.off_run,
                                s_r.oo_q, s_r.off_q, s_r.on_q};
                delay_timer_pkg::A_ON_EL:  s_nxt.rd = {6'h0, s_r.on_el};
                delay_timer_pkg::A_OFF_EL: s_nxt.rd = {6'h0, s_r.off_el};
                delay_timer_pkg::A_OO_EL:  s_nxt.rd = {6'h0, s_r.oo_el};
                default: begin
                    s_nxt.rd = 32'h0;
                    s_nxt.rr = 2'h2;
                end
            endcase
        end
        if (s_r.rv && s_axi_rready) begin
            s_nxt.rv = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r         <= '0;
            s_r.on_dly  <= delay_timer_pkg::DLY_RST;
            s_r.off_dly <= delay_timer_pkg::DLY_RST;
            s_r.hi_dly  <= delay_timer_pkg::DLY_RST;
            s_r.lo_dly  <= delay_timer_pkg::DLY_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign on_output     = s_r.on_q;
    assign off_output    = s_r.off_q;
    assign onoff_output  = s_r.oo_q;
    assign s_axi_awready = !s_r.aw_got;
    assign s_axi_wready  = !s_r.w_got;
    assign s_axi_bvalid  = s_r.bv;
    assign s_axi_bresp   = s_r.br;
    assign s_axi_arready = !s_r.rv;
    assign s_axi_rvalid  = s_r.rv;
    assign s_axi_rdata   = s_r.rd;
    assign s_axi_rresp   = s_r.rr;

    AST_ON_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        tick && !on_trigger |=> !on_output) // R04
        else $error("on-delay output high with trigger low");
    AST_ON_EL_CLR: assert property (@(posedge clk) disable iff (!rst_n)
        tick && !on_trigger && !power_lost |=> s_r.on_el == '0) // R03
        else $error("on-delay elapsed not cleared");
    AST_ON_START: assert property (@(posedge clk) disable iff (!rst_n)
        tick && on_trigger && !s_r.on_trg |=> s_r.on_el == '0) // R01
        else $error("on-delay did not restart from zero");
    AST_ON_RISE: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(on_output) |-> $past(on_trigger) && s_r.on_el >= t_on) // R02
        else $error("on-delay output rose early");
    AST_OFF_SET: assert property (@(posedge clk) disable iff (!rst_n)
        tick && off_trigger && !off_clear && !power_lost
        |=> off_output) // R10
        else $error("off-delay output not set by trigger");
    AST_OFF_CLR: assert property (@(posedge clk) disable iff (!rst_n)
        off_clear |=> !off_output && s_r.off_el == '0) // R13
        else $error("off-delay clear ignored");
    AST_OFF_FALL: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(off_output) && !$past(off_clear) && !$past(power_lost)
        |-> s_r.off_el >= t_off) // R11
        else $error("off-delay output fell early");
    AST_OO_FALL: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(onoff_output) && !$past(power_lost)
        |-> !$past(onoff_trigger)) // R17
        else $error("on/off output fell with trigger high");
    AST_OO_RISE: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(onoff_output) |-> $past(onoff_trigger)) // R14
        else $error("on/off output rose with trigger low");
endmodule
`default_nettype wire

// File: dv/logic_sources.sv
// partner model: registered binary outputs of neighbouring logic blocks
`timescale 1ns/1ps
`default_nettype none
module logic_sources (
    input  wire logic        clk,
    input  wire logic [3:0]  want,
    input  wire logic [63:0] want_src,
    output var logic         on_trigger,
    output var logic         off_trigger,
    output var logic         onoff_trigger,
    output var logic         off_clear,
    output var logic [63:0]  src_values
);
    // a block output changes once per evaluation, so it arrives a clock late
    initial begin
        {off_clear, onoff_trigger, off_trigger, on_trigger} = 4'h0;
        src_values = 64'h0;
    end
    always @(posedge clk) begin
        {off_clear, onoff_trigger, off_trigger, on_trigger} <= want;
        src_values <= want_src;
    end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the delay timer blocks
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk, arst_n, power_lost;
    logic [3:0]  want;
    logic [63:0] want_src;
    wire logic   on_trigger, off_trigger, onoff_trigger, off_clear;
    wire logic [63:0] src_values;
    logic        on_output, off_output, onoff_output;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          error_cnt, cmp_count, c, i;
    int unsigned seed = 27;
    logic [31:0] d;
    logic [1:0]  r;
    logic [63:0] sv;
    logic [7:0]  dly_a [4] = '{8'h04, 8'h08, 8'h0c, 8'h10};

    logic_sources partner_u (.clk(clk), .want(want), .want_src(want_src),
        .on_trigger(on_trigger), .off_trigger(off_trigger),
        .onoff_trigger(onoff_trigger), .off_clear(off_clear),
        .src_values(src_values));
    delay_timers #(.TICK_CYCLES(4)) dut_u (.clk(clk), .arst_n(arst_n),
        .power_lost(power_lost), .on_trigger(on_trigger),
        .off_trigger(off_trigger), .off_clear(off_clear),
        .onoff_trigger(onoff_trigger), .src_values(src_values),
        .on_output(on_output), .off_output(off_output),
        .onoff_output(onoff_output), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // reference model of the delay length in ticks
    function automatic int exp_ticks(input int w, input int s);
        int v;
        v = w[18] ? s : w % 65536;
        v = w[18] ? (v > 9995 ? 9995 : v) / 10 : (w[17:16] != 0 ? v * 100 : v);
        return v < 1 ? 1 : v;
    endfunction
    function automatic logic outv(input int k);
        return k == 0 ? on_output : (k == 1 ? off_output : onoff_output);
    endfunction
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v,
                      output logic [1:0] rs);
        logic aw, w;
        int n;
        aw = 1'b0;
        w = 1'b0;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w) && n < 200) begin
            @(posedge clk);
            n++;
            aw |= s_axi_awready === 1'b1;
            w |= s_axi_wready === 1'b1;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end
        while (s_axi_bvalid !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        check("wr_answer", n < 200, 1);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (s_axi_arready !== 1'b1 && n < 200);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        check("rd_answer", n < 200, 1);
    endtask
    task automatic set_in(input int k, input logic l);
        @(posedge clk);
        want[k] <= l;
    endtask
    task automatic wait_lvl(input int k, input logic l, input int lim);
        c = 0;
        while (outv(k) !== l && c < lim) begin
            @(posedge clk);
            c++;
        end
    endtask
    // ticks are unseen at the ports, so a change is accepted from one tick early to two ticks late
    task automatic expect_at(input string nm, input int k, input logic l,
                             input int n);
        wait_lvl(k, l, 4 * n + 40);
        check(nm, 32'(c >= 4 * n - 4 && c <= 4 * n + 8), 1);
    endtask
    task automatic short_then_full(input int k, input logic l);
        set_in(k, l);
        repeat (8) @(posedge clk);
        set_in(k, !l);
        repeat (6) @(posedge clk);
        check("short_pulse", outv(k), !l);
        set_in(k, l);
        expect_at("full_delay", k, l, 3);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #1ms;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        {arst_n, power_lost, want, want_src} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(32'h00, d, r);
        check("ctrl_reset", d, 0);
        rd(32'h04, d, r);
        check("on_delay_reset", d, 32'(delay_timer_pkg::DLY_RST));
        rd(32'h40, d, r);
        check("unmapped_data", d, 0);
        check("unmapped_resp", r, 2'h2);
        wr(32'h14, 32'h1, r);
        check("status_write_resp", r, 2'h2);
        foreach (dly_a[j]) wr(32'(dly_a[j]), 32'h3, r);
        $display("test registers done");
        short_then_full(0, 1'b1);
        set_in(0, 1'b0);
        expect_at("on_follows_low", 0, 1'b0, 0);
        short_then_full(2, 1'b1);
        short_then_full(2, 1'b0);
        $display("test on and on/off delay done");
        set_in(1, 1'b1);
        expect_at("off_sets_at_once", 1, 1'b1, 0);
        set_in(1, 1'b0);
        expect_at("off_falls", 1, 1'b0, 3);
        set_in(1, 1'b1);
        repeat (4) @(posedge clk);
        set_in(1, 1'b0);
        repeat (8) @(posedge clk);
        set_in(1, 1'b1);
        repeat (4) @(posedge clk);
        set_in(1, 1'b0);
        expect_at("off_retrigger", 1, 1'b0, 3);
        set_in(1, 1'b1);
        repeat (4) @(posedge clk);
        set_in(1, 1'b0);
        set_in(3, 1'b1);
        wait_lvl(1, 1'b0, 6);
        check("off_clear", 32'(c < 6), 1);
        set_in(3, 1'b0);
        $display("test off delay done");
        for (i = 0; i < 6; i++) begin
            sv = {rnd(), rnd()};
            sv[16 * (i % 4) +: 16] = i == 4 ? 16'hffff : 16'(10 * (i + 2));
            want_src <= sv;
            wr(32'h00, 32'((i % 4) << 3), r);
            d = i == 5 ? 32'h10001 : 32'h40000;
            wr(32'h04, d, r);
            set_in(0, 1'b1);
            expect_at("source_delay", 0, 1'b1,
                exp_ticks(d, sv[16 * (i % 4) +: 16]));
            set_in(0, 1'b0);
            repeat (8) @(posedge clk);
        end
        $display("test delay sources done");
        wr(32'h10, 32'd60, r);
        for (i = 0; i < 2; i++) begin
            wr(32'h00, 32'(i << 2), r);
            set_in(2, 1'b1);
            expect_at("oo_rise", 2, 1'b1, 3);
            set_in(2, 1'b0);
            repeat (12) @(posedge clk);
            power_lost <= 1'b1;
            @(posedge clk);
            power_lost <= 1'b0;
            repeat (4) @(posedge clk);
            check("retain_output", onoff_output, i);
            rd(32'h20, d, r);
            check("retain_elapsed", 32'(d != 0), i);
            wait_lvl(2, 1'b0, 300);
        end
        $display("test retention done");
        report_and_stop();
    end
endmodule
`default_nettype wire
